// >>> rtl/dmea_top.sv
// Data space decoder, SRAM, EEPROM access path and program memory
`timescale 1ns/1ps
`default_nettype none
`include "dmea_cfg.svh"
module dmea_top #(
  parameter int unsigned EE_WR_CYCLES = `DMEA_EE_WR_CYC,
  parameter int unsigned BOOT_WORDS   = `DMEA_BOOT_WORDS
) (
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  input  wire logic                  POWER_ON_N,
  input  wire dmea_pkg::dmea_req_s   REQ,
  output var  logic                  REQ_READY,
  output var  dmea_pkg::dmea_rsp_s   RSP,
  output var  logic                  CPU_HOLD,
  output var  logic                  EE_READY_IRQ,
  input  wire logic                  SLEEP_PD,
  output var  logic                  OSC_RUN,
  input  wire logic                  PC_LOAD,
  input  wire logic [`DMEA_PC_W-1:0] PC_TARGET,
  input  wire logic [1:0]            PC_STEP,
  output var  logic [`DMEA_PC_W-1:0] PC,
  output var  logic [31:0]           INSTR,
  input  wire logic                  PM_WE,
  input  wire logic [`DMEA_PC_W-1:0] PM_WADDR,
  input  wire logic [15:0]           PM_WDATA,
  input  wire logic                  BOOT_WR_EN
);
  import dmea_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_ACC
  } dmea_st_e;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]  rf_q   [32];
  logic [7:0]  sram_q [`DMEA_SRAM_BYTES];
  logic [15:0] pm_q   [`DMEA_PM_WORDS];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dmea_st_e               st_q, st_d;
  logic [15:0]            adr_q, adr_d;
  logic                   wr_q, wr_d;
  logic [7:0]             wdat_q, wdat_d;
  logic                   ready_q, ready_d;
  dmea_rsp_s              rsp_q, rsp_d;
  logic [2:0]             hold_q, hold_d;
  logic                   holdo_q, holdo_d;
  logic [`DMEA_EE_AW-1:0] eea_q, eea_d;
  logic [7:0]             eed_q, eed_d;
  logic                   rdyie_q, rdyie_d;
  logic                   arm_q, arm_d;
  logic [2:0]             armc_q, armc_d;
  logic                   irq_q, irq_d;
  logic                   osc_q, osc_d;
  logic [`DMEA_PC_W-1:0]  pc_q, pc_d;
  logic [31:0]            ins_q, ins_d;
  logic                   ee_start;
  logic                   ee_busy;
  logic [7:0]             ee_rdata;
  logic [15:0]            eff_adr;
  logic [15:0]            ptr_new;
  logic                   ptr_we;
  logic [4:0]             ptr_lo;
  logic                   ptr_wr;
  logic                   rf_we;
  logic                   sram_we;
  logic                   pm_wr_ok;
  logic [7:0]             rd_mux;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic dmea_rgn_e region(input logic [15:0] a);
    if (a <= `DMEA_RF_TOP) begin
      region = RG_RF;
    end else if (a < `DMEA_SRAM_BASE) begin
      region = RG_IO;
    end else if (a <= `DMEA_DATA_TOP) begin
      region = RG_SRAM;
    end else begin
      region = RG_NONE;
    end
  endfunction

  function automatic logic [10:0] sram_idx(input logic [15:0] a);
    logic [15:0] off;
    off      = a - `DMEA_SRAM_BASE;
    sram_idx = off[10:0];
  endfunction

  // ---------------------------------------------------------------
  // Address generation and EEPROM engine
  // ---------------------------------------------------------------
  dmea_agu u_agu (
    .mode        (REQ.mode),
    .ptr         (REQ.ptr),
    .direct_addr (REQ.addr),
    .disp        (REQ.disp),
    .ptr_a       ({rf_q[27], rf_q[26]}),
    .ptr_b       ({rf_q[29], rf_q[28]}),
    .ptr_c       ({rf_q[31], rf_q[30]}),
    .eff_addr    (eff_adr),
    .ptr_we      (ptr_we),
    .ptr_lo      (ptr_lo),
    .ptr_new     (ptr_new)
  );

  dmea_eewr #(
    .WR_CYCLES (EE_WR_CYCLES)
  ) u_eewr (
    .clk     (MCLK),
    .por_n   (POWER_ON_N),
    .start   (ee_start),
    .wr_addr (eea_q),
    .wr_data (eed_q),
    .rd_addr (eea_q),
    .rd_data (ee_rdata),
    .busy    (ee_busy)
  );

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = `DMEA_UNMAPPED_RD;
    unique case (region(adr_q))
      RG_RF:   rd_mux = rf_q[adr_q[4:0]];
      RG_SRAM: rd_mux = sram_q[sram_idx(adr_q)];
      RG_IO: begin
        case (adr_q)
          `DMEA_IO_EECR: rd_mux = {4'h0, rdyie_q, arm_q, ee_busy, 1'b0};
          `DMEA_IO_EEDR: rd_mux = eed_q;
          `DMEA_IO_EEAL: rd_mux = eea_q[7:0];
          `DMEA_IO_EEAH: rd_mux = {6'h00, eea_q[9:8]};
          default:       rd_mux = `DMEA_UNMAPPED_RD;
        endcase
      end
      RG_NONE: rd_mux = `DMEA_UNMAPPED_RD;
    endcase
  end

  // ---------------------------------------------------------------
  // Access sequencer and EEPROM control
  // ---------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    adr_d    = adr_q;
    wr_d     = wr_q;
    wdat_d   = wdat_q;
    rsp_d    = '{valid: 1'b0, data: rsp_q.data};
    hold_d   = (hold_q != 3'd0) ? hold_q - 3'd1 : 3'd0;
    eea_d    = eea_q;
    eed_d    = eed_q;
    rdyie_d  = rdyie_q;
    arm_d    = arm_q;
    armc_d   = armc_q;
    ee_start = 1'b0;
    ptr_wr   = 1'b0;
    rf_we    = 1'b0;
    sram_we  = 1'b0;
    if (armc_q != 3'd0) begin
      armc_d = armc_q - 3'd1;
      if (armc_q == 3'd1) begin
        arm_d = 1'b0;
      end
    end
    unique case (st_q)
      ST_IDLE: begin
        if (REQ.valid && ready_q) begin
          st_d   = ST_ACC;
          adr_d  = eff_adr;
          wr_d   = REQ.write;
          wdat_d = REQ.wdata;
          ptr_wr = ptr_we;
        end
      end
      ST_ACC: begin
        // Second cycle of every access completes it
        st_d        = ST_IDLE;
        rsp_d.valid = 1'b1;
        if (!wr_q) begin
          rsp_d.data = rd_mux;
        end else begin
          unique case (region(adr_q))
            RG_RF:   rf_we   = 1'b1;
            RG_SRAM: sram_we = 1'b1;
            RG_NONE: rf_we   = 1'b0;
            RG_IO: begin
              case (adr_q)
                `DMEA_IO_EECR: begin
                  rdyie_d = wdat_q[`DMEA_EECR_RDYIE];
                  if (wdat_q[`DMEA_EECR_ARM]) begin
                    arm_d  = 1'b1;
                    armc_d = `DMEA_ARM_CYC;
                  end
                  // A read is refused while a write is still running
                  if (wdat_q[`DMEA_EECR_READ] && !ee_busy) begin
                    eed_d  = ee_rdata;
                    hold_d = `DMEA_RD_HOLD;
                  end else if (wdat_q[`DMEA_EECR_STROBE] && arm_q &&
                               !ee_busy) begin
                    ee_start = 1'b1;
                    hold_d   = `DMEA_WR_HOLD;
                  end
                end
                `DMEA_IO_EEDR: eed_d = wdat_q;
                `DMEA_IO_EEAL: eea_d[7:0] = wdat_q;
                `DMEA_IO_EEAH: eea_d[9:8] = wdat_q[1:0];
                default:       eed_d = eed_q;
              endcase
            end
          endcase
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Status outputs and program counter
  // ---------------------------------------------------------------
  always_comb begin
    ready_d  = (st_d == ST_IDLE) && (hold_d == 3'd0);
    holdo_d  = (hold_d != 3'd0);
    irq_d    = rdyie_d && !ee_busy;
    // The write keeps the oscillator alive, so power-down is partial
    osc_d    = !(SLEEP_PD && !ee_busy);
    pc_d     = pc_q;
    if (PC_LOAD) begin
      pc_d = PC_TARGET;
    end else if (!holdo_q) begin
      pc_d = pc_q + {12'h000, PC_STEP};
    end
    ins_d    = {pm_q[pc_d], pm_q[pc_d + 14'h0001]};
    pm_wr_ok = PM_WE && ((32'(PM_WADDR) < `DMEA_PM_WORDS - BOOT_WORDS) ||
                         BOOT_WR_EN);
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q    <= ST_IDLE;
      adr_q   <= 16'h0000;
      wr_q    <= 1'b0;
      wdat_q  <= 8'h00;
      ready_q <= 1'b0;
      rsp_q   <= '0;
      hold_q  <= 3'd0;
      holdo_q <= 1'b0;
      eea_q   <= '0;
      eed_q   <= 8'h00;
      rdyie_q <= 1'b0;
      arm_q   <= 1'b0;
      armc_q  <= 3'd0;
      irq_q   <= 1'b0;
      osc_q   <= 1'b1;
      pc_q    <= '0;
      ins_q   <= 32'h0000_0000;
    end else begin
      st_q    <= st_d;
      adr_q   <= adr_d;
      wr_q    <= wr_d;
      wdat_q  <= wdat_d;
      ready_q <= ready_d;
      rsp_q   <= rsp_d;
      hold_q  <= hold_d;
      holdo_q <= holdo_d;
      eea_q   <= eea_d;
      eed_q   <= eed_d;
      rdyie_q <= rdyie_d;
      arm_q   <= arm_d;
      armc_q  <= armc_d;
      irq_q   <= irq_d;
      osc_q   <= osc_d;
      pc_q    <= pc_d;
      ins_q   <= ins_d;
    end
  end

  // ---------------------------------------------------------------
  // Memory arrays, no reset so they map to plain storage
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (ptr_wr) begin
      rf_q[ptr_lo]              <= ptr_new[7:0];
      rf_q[ptr_lo + 5'd1]       <= ptr_new[15:8];
    end
    if (rf_we) begin
      rf_q[adr_q[4:0]]          <= wdat_q;
    end
    if (sram_we) begin
      sram_q[sram_idx(adr_q)]   <= wdat_q;
    end
    if (pm_wr_ok) begin
      pm_q[PM_WADDR]            <= PM_WDATA;
    end
  end

  assign REQ_READY    = ready_q;
  assign RSP          = rsp_q;
  assign CPU_HOLD     = holdo_q;
  assign EE_READY_IRQ = irq_q;
  assign OSC_RUN      = osc_q;
  assign PC           = pc_q;
  assign INSTR        = ins_q;
endmodule
`default_nettype wire

// >>> rtl/dmea_cfg.svh
// Constants for the data memory and EEPROM access block
`ifndef DMEA_CFG_SVH
`define DMEA_CFG_SVH
// How it works
// - Program memory holds 16K words of 16 bits; instructions use one or two.
// - Program counter is 14 bits wide and reaches every program word.
// - Program memory splits into boot and application regions for protection.
// - Lowest 2144 data locations: 96 register/I/O, then 2048 SRAM.
// - Registers from zero, I/O from 0x0020, SRAM from 0x0060.
// - Five modes: direct, indirect, displacement, pre-decrement, post-increment.
// - Registers 26 to 31 form the three pointers a, b and c.
// - Direct addressing reaches the whole data space.
// - Displacement adds up to 63 to pointer b or c.
// - Pre-decrement lowers pointer before access; post-increment raises after.
// - Each SRAM data access takes two clock cycles.
// - 1 Kbyte data EEPROM, separate space, byte read and write.
// - EEPROM address, data and control registers sit in I/O space.
// - EEPROM writes are self-timed with a pollable completion flag.
// - A write starts only through the protective arm-then-strobe sequence.
// - CPU is held four cycles after an EEPROM read is triggered.
// - CPU is held two cycles after an EEPROM write is started.
// - A running write finishes in power-down; oscillator runs until it ends.
// - A running write completes even when reset is asserted.
// - Arm clears itself four cycles after set; strobe inside starts write.
// - Strobe set while arm is zero does nothing.
// - Hardware clears the strobe when the write time has elapsed.
// - EEPROM address is ten bits across a low and a high register.
`define DMEA_PM_WORDS    16384
`define DMEA_PC_W        14
`define DMEA_BOOT_WORDS  2048
`define DMEA_RF_TOP      16'h001f
`define DMEA_SRAM_BASE   16'h0060
`define DMEA_DATA_TOP    16'h085f
`define DMEA_SRAM_BYTES  2048
`define DMEA_EE_BYTES    1024
`define DMEA_EE_AW       10
`define DMEA_IO_EECR     16'h003c
`define DMEA_IO_EEDR     16'h003d
`define DMEA_IO_EEAL     16'h003e
`define DMEA_IO_EEAH     16'h003f
`define DMEA_EECR_READ   0
`define DMEA_EECR_STROBE 1
`define DMEA_EECR_ARM    2
`define DMEA_EECR_RDYIE  3
`define DMEA_PTR_A_LO    5'd26
`define DMEA_PTR_B_LO    5'd28
`define DMEA_PTR_C_LO    5'd30
`define DMEA_ARM_CYC     3'd4
`define DMEA_RD_HOLD     3'd4
`define DMEA_WR_HOLD     3'd2
`define DMEA_UNMAPPED_RD 8'h00
`define DMEA_CLK_NS      4
`define DMEA_EE_WR_NS    8500000
`define DMEA_EE_WR_CYC   ((`DMEA_EE_WR_NS + `DMEA_CLK_NS - 1) / `DMEA_CLK_NS)
`endif

// >>> rtl/dmea_pkg.sv
// Types shared by the data memory and EEPROM access block
package dmea_pkg;
  typedef enum logic [2:0] {
    AM_DIRECT,
    AM_IND,
    AM_DISP,
    AM_PREDEC,
    AM_POSTINC
  } dmea_mode_e;
  typedef enum logic [1:0] {
    PTR_A,
    PTR_B,
    PTR_C
  } dmea_ptr_e;
  typedef enum logic [1:0] {
    RG_RF,
    RG_IO,
    RG_SRAM,
    RG_NONE
  } dmea_rgn_e;
  typedef struct packed {
    logic        valid;
    logic        write;
    dmea_mode_e  mode;
    dmea_ptr_e   ptr;
    logic [15:0] addr;
    logic [5:0]  disp;
    logic [7:0]  wdata;
  } dmea_req_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dmea_rsp_s;
endpackage

// >>> rtl/dmea_agu.sv
// Data address generator for the five addressing modes
`timescale 1ns/1ps
`default_nettype none
`include "dmea_cfg.svh"
module dmea_agu (
  input  wire dmea_pkg::dmea_mode_e mode,
  input  wire dmea_pkg::dmea_ptr_e  ptr,
  input  wire logic [15:0]          direct_addr,
  input  wire logic [5:0]           disp,
  input  wire logic [15:0]          ptr_a,
  input  wire logic [15:0]          ptr_b,
  input  wire logic [15:0]          ptr_c,
  output logic [15:0]               eff_addr,
  output logic                      ptr_we,
  output logic [4:0]                ptr_lo,
  output logic [15:0]               ptr_new
);
  import dmea_pkg::*;
  logic [15:0] base;
  always_comb begin
    // Displacement has no pointer a form, so a falls back to b
    unique case (ptr)
      PTR_A:   base = (mode == AM_DISP) ? ptr_b : ptr_a;
      PTR_B:   base = ptr_b;
      PTR_C:   base = ptr_c;
      default: base = ptr_b;
    endcase
    unique case (ptr)
      PTR_A:   ptr_lo = (mode == AM_DISP) ? `DMEA_PTR_B_LO : `DMEA_PTR_A_LO;
      PTR_C:   ptr_lo = `DMEA_PTR_C_LO;
      default: ptr_lo = `DMEA_PTR_B_LO;
    endcase
    ptr_we   = 1'b0;
    ptr_new  = base;
    eff_addr = base;
    unique case (mode)
      AM_DIRECT: eff_addr = direct_addr;
      AM_IND:    eff_addr = base;
      AM_DISP:   eff_addr = base + {10'h000, disp};
      AM_PREDEC: begin
        eff_addr = base - 16'h0001;
        ptr_new  = base - 16'h0001;
        ptr_we   = 1'b1;
      end
      AM_POSTINC: begin
        ptr_new = base + 16'h0001;
        ptr_we  = 1'b1;
      end
      default: eff_addr = direct_addr;
    endcase
  end
endmodule
`default_nettype wire

// >>> rtl/dmea_eewr.sv
// Self-timed EEPROM write engine and byte array
`timescale 1ns/1ps
`default_nettype none
`include "dmea_cfg.svh"
module dmea_eewr #(
  parameter int unsigned WR_CYCLES = `DMEA_EE_WR_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   por_n,
  input  wire logic                   start,
  input  wire logic [`DMEA_EE_AW-1:0] wr_addr,
  input  wire logic [7:0]             wr_data,
  input  wire logic [`DMEA_EE_AW-1:0] rd_addr,
  output logic [7:0]                  rd_data,
  output logic                        busy
);
  localparam int unsigned CW = $clog2(WR_CYCLES + 1);
  logic [7:0]             mem_q [`DMEA_EE_BYTES];
  logic                   busy_q, busy_d;
  logic [CW-1:0]          cnt_q, cnt_d;
  logic [`DMEA_EE_AW-1:0] a_q, a_d;
  logic [7:0]             d_q, d_d;
  logic                   done;
  always_comb begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    a_d    = a_q;
    d_d    = d_q;
    done   = 1'b0;
    if (busy_q) begin
      cnt_d = cnt_q - CW'(1);
      if (cnt_q == CW'(1)) begin
        busy_d = 1'b0;
        done   = 1'b1;
      end
    end else if (start) begin
      // Address and data are latched so later register edits cannot tear it
      busy_d = 1'b1;
      cnt_d  = CW'(WR_CYCLES);
      a_d    = wr_addr;
      d_d    = wr_data;
    end
  end
  // Only power-on clears the engine; system reset lets a write finish
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      a_q    <= '0;
      d_q    <= 8'h00;
    end else begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      a_q    <= a_d;
      d_q    <= d_d;
    end
  end
  always_ff @(posedge clk) begin
    if (done) begin
      mem_q[a_q] <= d_q;
    end
  end
  assign rd_data = mem_q[rd_addr];
  assign busy    = busy_q;
endmodule
`default_nettype wire

// >>> testbench/dmea_assertions.sv
// Port-level checks for the data memory and EEPROM access block
`timescale 1ns/1ps
`default_nettype none
`include "dmea_cfg.svh"
module dmea_assertions #(
  parameter int unsigned EE_WR_CYCLES = 20,
  parameter int unsigned BOOT_WORDS   = 2048
) (
  input wire logic                  MCLK,
  input wire logic                  RESET_N,
  input wire dmea_pkg::dmea_req_s   REQ,
  input wire logic                  REQ_READY,
  input wire dmea_pkg::dmea_rsp_s   RSP,
  input wire logic                  CPU_HOLD,
  input wire logic                  EE_READY_IRQ,
  input wire logic                  SLEEP_PD,
  input wire logic                  OSC_RUN,
  input wire logic                  PC_LOAD,
  input wire logic [`DMEA_PC_W-1:0] PC_TARGET,
  input wire logic [1:0]            PC_STEP,
  input wire logic [`DMEA_PC_W-1:0] PC
);
  import dmea_pkg::*;
  logic       taken;
  logic       ee_rd;
  logic [3:0] hold_q;
  logic [3:0] hold_d;
  assign taken = REQ.valid && REQ_READY;
  // Ready interrupt high proves no write runs, so the read must be honoured
  assign ee_rd = taken && REQ.write && REQ.mode == AM_DIRECT &&
                 REQ.addr == `DMEA_IO_EECR && REQ.wdata[0] && EE_READY_IRQ;
  always_comb begin
    hold_d = CPU_HOLD ? hold_q + 4'h1 : 4'h0;
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_q <= 4'h0;
    end else begin
      hold_q <= hold_d;
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_rd_stall;
    ##2 CPU_HOLD [*4] ##1 !CPU_HOLD;
  endsequence
  chk_rsp_late: assert property (taken |-> ##2 RSP.valid)
    else $error("data answer not two cycles after request");
  chk_rsp_cause: assert property (RSP.valid |-> $past(taken, 2))
    else $error("data answer without request");
  chk_busy_gap: assert property (taken |=> !REQ_READY)
    else $error("request taken during access");
  chk_hold_block: assert property (CPU_HOLD |-> !REQ_READY)
    else $error("request accepted while cpu held");
  chk_rd_stall: assert property (ee_rd |-> s_rd_stall)
    else $error("eeprom read stall not four cycles");
  chk_hold_len: assert property ($fell(CPU_HOLD) |->
    hold_q == 4'h2 || hold_q == 4'h4)
    else $error("cpu hold of wrong length");
  chk_osc_awake: assert property (!SLEEP_PD |=> OSC_RUN)
    else $error("oscillator stopped without sleep request");
  chk_pc_step: assert property (!PC_LOAD && !CPU_HOLD |=>
    PC == $past(PC) + {12'h000, $past(PC_STEP)})
    else $error("program counter step wrong");
  chk_pc_load: assert property (PC_LOAD && !CPU_HOLD |=>
    PC == $past(PC_TARGET))
    else $error("program counter load wrong");
  chk_pc_freeze: assert property (CPU_HOLD |=> $stable(PC))
    else $error("program counter moved while held");
endmodule
`default_nettype wire

// >>> testbench/dmea_cpu_model.sv
// CPU-side model issuing one data access at a time
`timescale 1ns/1ps
`default_nettype none
module dmea_cpu_model (
  input  wire logic                MCLK,
  output var  dmea_pkg::dmea_req_s REQ,
  input  wire logic                REQ_READY,
  input  wire dmea_pkg::dmea_rsp_s RSP
);
  import dmea_pkg::*;
  initial begin
    REQ = '0;
  end
  // Called just after an edge; holds the request until ready is sampled
  task automatic access(input logic wr, input dmea_mode_e m,
                        input dmea_ptr_e p, input logic [15:0] a,
                        input logic [5:0] d, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    n = 0;
    REQ = '{1'b1, wr, m, p, a, d, wd};
    do begin
      @(posedge MCLK);
      n++;
    end while (REQ_READY !== 1'b1 && n < 40);
    #1;
    // Released write flag, address, displacement and data are inverted so stale values cannot pass
    REQ = '{1'b0, ~wr, m, p, ~a, ~d, ~wd};
    if (n < 40) begin
      @(posedge MCLK);
      @(posedge MCLK);
      ok = (RSP.valid === 1'b1);
      rd = RSP.data;
      #1;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_dmea_top.sv
// Self-checking bench for the data memory and EEPROM access block
`timescale 1ns/1ps
`default_nettype none
`include "dmea_cfg.svh"
module tb_dmea_top;
  import dmea_pkg::*;
  localparam int unsigned WR_CYC = 20;
  localparam logic [15:0] CTL = `DMEA_IO_EECR;
  localparam logic [15:0] DAT = `DMEA_IO_EEDR;
  logic        mclk, reset_n, power_on_n, req_ready, cpu_hold, irq;
  logic        sleep_pd, osc_run, pc_load, pm_we, boot_wr_en;
  dmea_req_s   req;
  dmea_rsp_s   rsp;
  logic [13:0] pc_target, pc, pm_waddr;
  logic [1:0]  pc_step;
  logic [31:0] instr;
  logic [15:0] pm_wdata;
  logic [7:0]  rd;
  int          error_cnt;
  int          compares;
  dmea_top #(
    .EE_WR_CYCLES (WR_CYC)
  ) u_dmea_top (
    .MCLK         (mclk),
    .RESET_N      (reset_n),
    .POWER_ON_N   (power_on_n),
    .REQ          (req),
    .REQ_READY    (req_ready),
    .RSP          (rsp),
    .CPU_HOLD     (cpu_hold),
    .EE_READY_IRQ (irq),
    .SLEEP_PD     (sleep_pd),
    .OSC_RUN      (osc_run),
    .PC_LOAD      (pc_load),
    .PC_TARGET    (pc_target),
    .PC_STEP      (pc_step),
    .PC           (pc),
    .INSTR        (instr),
    .PM_WE        (pm_we),
    .PM_WADDR     (pm_waddr),
    .PM_WDATA     (pm_wdata),
    .BOOT_WR_EN   (boot_wr_en)
  );
  dmea_cpu_model u_dmea_cpu_model (
    .MCLK      (mclk),
    .REQ       (req),
    .REQ_READY (req_ready),
    .RSP       (rsp)
  );
  task automatic conclude();
    $display("Mismatches %0d of %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chkv(input string n, input logic [31:0] e,
                      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    chkv(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic acc(input logic w, input dmea_mode_e m, input dmea_ptr_e p,
                     input logic [15:0] a, input logic [5:0] d,
                     input logic [7:0] wd);
    logic ok;
    u_dmea_cpu_model.access(w, m, p, a, d, wd, rd, ok);
    chkb("access answered", 1'b1, ok);
    if (ok !== 1'b1) begin
      conclude();
    end
  endtask
  task automatic st(input logic [15:0] a, input logic [7:0] wd);
    acc(1'b1, AM_DIRECT, PTR_A, a, 6'h00, wd);
  endtask
  task automatic ldc(input string n, input logic [15:0] a,
                     input logic [7:0] e);
    acc(1'b0, AM_DIRECT, PTR_A, a, 6'h00, 8'h00);
    chkv(n, {24'h0, e}, {24'h0, rd});
  endtask
  // Arm then strobe on back-to-back stores, inside the arm window
  task automatic ee_wr(input logic [9:0] a, input logic [7:0] d,
                       input logic [7:0] ie);
    st(`DMEA_IO_EEAL, a[7:0]);
    st(`DMEA_IO_EEAH, {6'h00, a[9:8]});
    st(DAT, d);
    st(CTL, 8'h04 | ie);
    st(CTL, 8'h02 | ie);
  endtask
  task automatic ee_rdc(input string n, input logic [9:0] a,
                        input logic [7:0] e);
    st(`DMEA_IO_EEAL, a[7:0]);
    st(`DMEA_IO_EEAH, {6'h00, a[9:8]});
    st(DAT, 8'h00);
    st(CTL, 8'h09);
    ldc(n, DAT, e);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      ticks(1);
      n++;
    end
    chkb("write done", 1'b1, irq);
    if (n == 100) begin
      conclude();
    end
  endtask
  task automatic t_sram();
    st(16'h0060, 8'h3a);
    st(16'h085f, 8'hc5);
    st(16'h0005, 8'h77);
    st(16'h0860, 8'h99);
    ldc("sram first", 16'h0060, 8'h3a);
    ldc("sram last", 16'h085f, 8'hc5);
    ldc("reg file", 16'h0005, 8'h77);
    ldc("unmapped", 16'h0860, `DMEA_UNMAPPED_RD);
  endtask
  task automatic t_modes();
    st(16'h001a, 8'hff);
    st(16'h001b, 8'h03);
    st(16'h001c, 8'h00);
    st(16'h001d, 8'h02);
    st(16'h001e, 8'h00);
    st(16'h001f, 8'h04);
    acc(1'b1, AM_DISP, PTR_B, 16'h0000, 6'h3f, 8'h5a);
    ldc("disp", 16'h023f, 8'h5a);
    acc(1'b1, AM_POSTINC, PTR_A, 16'h0000, 6'h00, 8'h11);
    ldc("inc low", 16'h001a, 8'h00);
    ldc("inc high", 16'h001b, 8'h04);
    acc(1'b0, AM_PREDEC, PTR_A, 16'h0000, 6'h00, 8'h00);
    chkv("predec data", 32'h11, {24'h0, rd});
    ldc("dec high", 16'h001b, 8'h03);
    acc(1'b1, AM_IND, PTR_C, 16'h0000, 6'h00, 8'he7);
    ldc("indirect", 16'h0400, 8'he7);
  endtask
  task automatic t_ee();
    ee_wr(10'h3ff, 8'ha5, 8'h08);
    ticks(3);
    chkb("irq busy", 1'b0, irq);
    acc(1'b0, AM_DIRECT, PTR_A, CTL, 6'h00, 8'h00);
    chkb("busy flag", 1'b1, rd[1]);
    wait_irq();
    ldc("ctl idle", CTL, 8'h08);
    ee_rdc("ee byte", 10'h3ff, 8'ha5);
  endtask
  task automatic t_arm();
    st(DAT, 8'h3c);
    st(CTL, 8'h0a);
    ticks(3);
    chkb("strobe no arm", 1'b1, irq);
    st(CTL, 8'h0c);
    ticks(6);
    st(CTL, 8'h0a);
    ticks(3);
    chkb("arm expired", 1'b1, irq);
    ee_rdc("byte kept", 10'h3ff, 8'ha5);
  endtask
  task automatic t_reset();
    int n;
    ee_wr(10'h010, 8'h96, 8'h00);
    ticks(3);
    reset_n = 1'b0;
    ticks(3);
    reset_n = 1'b1;
    ticks(2);
    acc(1'b0, AM_DIRECT, PTR_A, CTL, 6'h00, 8'h00);
    chkb("busy after reset", 1'b1, rd[1]);
    n = 0;
    while (rd[1] !== 1'b0 && n < 30) begin
      acc(1'b0, AM_DIRECT, PTR_A, CTL, 6'h00, 8'h00);
      n++;
    end
    chkb("busy ends", 1'b0, rd[1]);
    if (rd[1] !== 1'b0) begin
      conclude();
    end
    ee_rdc("survives reset", 10'h010, 8'h96);
  endtask
  task automatic t_sleep();
    ee_wr(10'h011, 8'h5a, 8'h08);
    sleep_pd = 1'b1;
    ticks(3);
    chkb("osc in write", 1'b1, osc_run);
    wait_irq();
    ticks(2);
    chkb("osc stops", 1'b0, osc_run);
    sleep_pd = 1'b0;
    ticks(2);
  endtask
  task automatic pm_wr(input logic [13:0] a, input logic [15:0] d);
    pm_waddr = a;
    pm_wdata = d;
    pm_we = 1'b1;
    ticks(1);
  endtask
  task automatic ld_pc(input logic [13:0] t);
    pc_target = t;
    pc_load = 1'b1;
    ticks(1);
  endtask
  task automatic t_pc();
    pm_wr(14'h0000, 16'h1234);
    pm_wr(14'h0001, 16'hbeef);
    boot_wr_en = 1'b1;
    pm_wr(14'h3800, 16'h0f0f);
    boot_wr_en = 1'b0;
    pm_wr(14'h3800, 16'hdead);
    pm_we = 1'b0;
    ld_pc(14'h0000);
    chkv("instr pair", 32'h1234beef, instr);
    ld_pc(14'h3800);
    chkv("boot kept", 32'h0f0f, {16'h0, instr[31:16]});
    ld_pc(14'h3fff);
    pc_load = 1'b0;
    pc_step = 2'h1;
    ticks(1);
    chkv("pc wrap", 32'h0, {18'h0, pc});
    pc_step = 2'h2;
    ticks(1);
    chkv("pc two", 32'h2, {18'h0, pc});
    pc_step = 2'h0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    error_cnt = 0;
    compares = 0;
    reset_n = 1'b0;
    power_on_n = 1'b0;
    sleep_pd = 1'b0;
    pc_load = 1'b0;
    pc_target = 14'h0000;
    pc_step = 2'h1;
    pm_we = 1'b0;
    pm_waddr = 14'h0000;
    pm_wdata = 16'h0000;
    boot_wr_en = 1'b0;
    ticks(20);
    reset_n = 1'b1;
    power_on_n = 1'b1;
    ticks(2);
    t_sram();
    t_modes();
    t_ee();
    t_arm();
    t_reset();
    t_sleep();
    t_pc();
    conclude();
  end
endmodule
bind dmea_top dmea_assertions #(
  .EE_WR_CYCLES (EE_WR_CYCLES),
  .BOOT_WORDS   (BOOT_WORDS)
) u_dmea_assertions (
  .MCLK         (MCLK),
  .RESET_N      (RESET_N),
  .REQ          (REQ),
  .REQ_READY    (REQ_READY),
  .RSP          (RSP),
  .CPU_HOLD     (CPU_HOLD),
  .EE_READY_IRQ (EE_READY_IRQ),
  .SLEEP_PD     (SLEEP_PD),
  .OSC_RUN      (OSC_RUN),
  .PC_LOAD      (PC_LOAD),
  .PC_TARGET    (PC_TARGET),
  .PC_STEP      (PC_STEP),
  .PC           (PC)
);
`default_nettype wire
